// >>> include/fbc_pkg.sv
// Package: constants for the flash bus host controller.
// Assumes one 50 MHz clock and a 512K x 8 die per byte lane.
package fbc_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int LANES = 4;
    // Command addresses and codes
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_1 = 19'h0_5555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_2 = 19'h0_2AAA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA_1 = 8'hAA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA_2 = 8'h55;
    localparam logic [DATA_W-1:0] CMD_RESET = 8'hF0;
    localparam logic [DATA_W-1:0] CMD_AUTOSEL = 8'h90;
    localparam logic [DATA_W-1:0] CMD_PROGRAM = 8'hA0;
    localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 8'h30;
    localparam int POLL_BIT = 7;
    localparam int SECTOR_LSB = 16;
    // Operation codes on the user port
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_RESET = 3'h1;
    localparam logic [2:0] OP_AUTOSEL = 3'h2;
    localparam logic [2:0] OP_PROGRAM = 3'h3;
    localparam logic [2:0] OP_CHIP_ERASE = 3'h4;
    localparam logic [2:0] OP_SECTOR_ERASE = 3'h5;
    // Bus timing
    localparam int CLK_NS = 20;
    localparam int ACCESS_NS = 150;
    localparam int WRITE_PULSE_NS = 50;
    localparam int WRITE_HIGH_NS = 20;
    localparam int FLOAT_NS = 35;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC = (WRITE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int FLOAT_CYC = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int POLL_LIMIT = 4000;
endpackage

// >>> include/fbc_cyc_if.sv
// Interface: one bus cycle request between sequencer and pin driver.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
interface fbc_cyc_if;
    logic req;
    logic wr;
    logic [18:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport seq (output req, output wr, output addr, output wdata,
        input done, input rdata);
    modport drv (input req, input wr, input addr, input wdata,
        output done, output rdata);
endinterface
`default_nettype wire

// >>> rtl/fbc_pin_drv.sv
// Pin driver: runs one read or write bus cycle on the flash pins.
// Assumes data inputs are synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module fbc_pin_drv
    import fbc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    fbc_cyc_if.drv cyc,
    input wire logic [DATA_W-1:0] i_dq,
    output logic o_cs_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [ADDR_W-1:0] o_addr,
    output logic [DATA_W-1:0] o_dq,
    output logic o_dq_oe
);
    typedef enum {S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_READ, S_FLOAT}
        fbc_drv_type;
    fbc_drv_type state_reg;
    logic [3:0] cnt_reg;
    logic wr_reg;
    wire cnt_zero = (cnt_reg == 4'h0);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= S_IDLE;
            cnt_reg <= 4'h0;
            wr_reg <= 1'b0;
            o_cs_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;
            o_addr <= '0;
            o_dq <= '0;
            o_dq_oe <= 1'b0;
            cyc.done <= 1'b0;
            cyc.rdata <= '0;
        end else begin
            cyc.done <= 1'b0;
            if (!cnt_zero) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
            case (state_reg)
                S_IDLE: if (cyc.req) begin
                    // Address set up before strobes; OE high for writes
                    o_addr <= cyc.addr;
                    o_dq <= cyc.wdata;
                    wr_reg <= cyc.wr;
                    o_cs_n <= 1'b0;
                    state_reg <= S_SETUP;
                end
                S_SETUP: begin
                    if (wr_reg) begin
                        // Write only with CS low, OE high, WE low
                        o_oe_n <= 1'b1;
                        o_dq_oe <= 1'b1;
                        o_we_n <= 1'b0;
                        cnt_reg <= 4'(WP_CYC - 1);
                        state_reg <= S_PULSE;
                    end else begin
                        o_dq_oe <= 1'b0;
                        o_oe_n <= 1'b0;
                        cnt_reg <= 4'(ACCESS_CYC - 1);
                        state_reg <= S_READ;
                    end
                end
                S_PULSE: if (cnt_zero) begin
                    // Device latches data at this rising edge
                    o_we_n <= 1'b1;
                    cnt_reg <= 4'(WPH_CYC - 1);
                    state_reg <= S_HOLD;
                end
                S_HOLD: if (cnt_zero) begin
                    o_cs_n <= 1'b1;
                    o_dq_oe <= 1'b0;
                    cyc.done <= 1'b1;
                    state_reg <= S_IDLE;
                end
                S_READ: if (cnt_zero) begin
                    cyc.rdata <= i_dq;
                    o_oe_n <= 1'b1;
                    o_cs_n <= 1'b1;
                    // Let the device float before we drive again
                    cnt_reg <= 4'(FLOAT_CYC - 1);
                    state_reg <= S_FLOAT;
                end
                S_FLOAT: if (cnt_zero) begin
                    cyc.done <= 1'b1;
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> rtl/fbc_host.sv
// Host controller: issues flash command sequences on the device pins.
// Assumes one die per byte lane; each lane's chip select picks its die.
//==============================================================
`timescale 1ns/1ps
`default_nettype none
module fbc_host
    import fbc_pkg::*;
#(
    parameter int POLL_MAX = POLL_LIMIT
)(
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_ARST_N,
    // User command port
    input wire logic I_CMD_VALID,
    input wire logic [2:0] I_CMD_OP,
    input wire logic [ADDR_W-1:0] I_CMD_ADDR,
    input wire logic [DATA_W-1:0] I_CMD_DATA,
    input wire logic [1:0] I_CMD_LANE,
    output logic O_CMD_READY,
    output logic O_RSP_VALID,
    output logic [DATA_W-1:0] O_RSP_DATA,
    output logic O_RSP_TIMEOUT,
    output logic O_PROG_ZERO_TO_ONE,
    // Flash pins
    output logic [LANES-1:0] O_CS_N,
    output logic O_OE_N,
    output logic O_WE_N,
    output logic [ADDR_W-1:0] O_ADDR,
    input wire logic [LANES*DATA_W-1:0] I_DQ,
    output logic [LANES*DATA_W-1:0] O_DQ,
    output logic [LANES-1:0] O_DQ_OE
);
    initial begin
        if (POLL_MAX < 1 || POLL_MAX > 65535) begin
            $error("POLL_MAX out of range");
        end
    end

    //==============================================================
    // Sequencer
    typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT, ST_POLL, ST_POLL_WAIT,
        ST_REPLY} fbc_seq_type;
    fbc_seq_type state_reg;
    fbc_cyc_if cyc();
    logic [2:0] op_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] data_reg;
    logic [1:0] lane_reg;
    logic [2:0] step_reg;
    logic [15:0] poll_reg;
    logic req_reg;
    logic [ADDR_W-1:0] cyc_addr_reg;
    logic [DATA_W-1:0] cyc_data_reg;
    logic wr_reg;

    // Step count per operation, poll bit target
    // Autoselect is three writes, program four, erase six
    wire [2:0] last_step = (op_reg == OP_RESET) ? 3'd0 :
        (op_reg == OP_AUTOSEL) ? 3'd2 :
        (op_reg == OP_PROGRAM) ? 3'd3 :
        (op_reg == OP_READ) ? 3'd0 : 3'd5;
    wire needs_poll = (op_reg == OP_PROGRAM) ||
        (op_reg == OP_CHIP_ERASE) || (op_reg == OP_SECTOR_ERASE);
    wire poll_goal = (op_reg == OP_PROGRAM) ? data_reg[POLL_BIT] : 1'b1;
    // Erase ends when the poll bit reads 1; program when it matches
    wire poll_ok = (cyc.rdata[POLL_BIT] == poll_goal);
    // Erase polls within the sector being erased
    wire [ADDR_W-1:0] sector_addr = {addr_reg[ADDR_W-1:SECTOR_LSB],
        16'h0000};
    wire [ADDR_W-1:0] poll_addr = (op_reg == OP_PROGRAM) ? addr_reg :
        sector_addr;
    wire [DATA_W-1:0] rd_bits = cyc.rdata;

    // Address and data of each step; upper bits zero in commands except the program data and sector erase steps
    logic [ADDR_W-1:0] step_addr;
    logic [DATA_W-1:0] step_data;
    always_comb begin
        step_addr = UNLOCK_ADDR_1;
        step_data = UNLOCK_DATA_1;
        case (step_reg)
            3'd0: begin
                if (op_reg == OP_RESET) begin
                    step_data = CMD_RESET;
                end
            end
            3'd1: begin
                step_addr = UNLOCK_ADDR_2;
                step_data = UNLOCK_DATA_2;
            end
            3'd2: begin
                if (op_reg == OP_AUTOSEL) begin
                    step_data = CMD_AUTOSEL;
                end else if (op_reg == OP_PROGRAM) begin
                    step_data = CMD_PROGRAM;
                end else begin
                    step_data = CMD_ERASE_SETUP;
                end
            end
            3'd3: begin
                if (op_reg == OP_PROGRAM) begin
                    // Any address, any order
                    step_addr = addr_reg;
                    step_data = data_reg;
                end
            end
            3'd4: begin
                step_addr = UNLOCK_ADDR_2;
                step_data = UNLOCK_DATA_2;
            end
            default: begin
                if (op_reg == OP_SECTOR_ERASE) begin
                    step_addr = sector_addr;
                    step_data = CMD_SECTOR_ERASE;
                end else begin
                    step_data = CMD_CHIP_ERASE;
                end
            end
        endcase
    end

    assign cyc.req = req_reg;
    assign cyc.wr = wr_reg;
    assign cyc.addr = cyc_addr_reg;
    assign cyc.wdata = cyc_data_reg;

    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_READ;
            addr_reg <= '0;
            data_reg <= '0;
            lane_reg <= 2'h0;
            step_reg <= 3'h0;
            poll_reg <= 16'h0000;
            req_reg <= 1'b0;
            wr_reg <= 1'b0;
            cyc_addr_reg <= '0;
            cyc_data_reg <= '0;
            O_CMD_READY <= 1'b0;
            O_RSP_VALID <= 1'b0;
            O_RSP_DATA <= '0;
            O_RSP_TIMEOUT <= 1'b0;
            O_PROG_ZERO_TO_ONE <= 1'b0;
        end else begin
            req_reg <= 1'b0;
            O_RSP_VALID <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    O_CMD_READY <= 1'b1;
                    if (I_CMD_VALID && O_CMD_READY) begin
                        O_CMD_READY <= 1'b0;
                        op_reg <= I_CMD_OP;
                        addr_reg <= I_CMD_ADDR;
                        data_reg <= I_CMD_DATA;
                        lane_reg <= I_CMD_LANE;
                        step_reg <= 3'h0;
                        poll_reg <= 16'h0000;
                        O_RSP_TIMEOUT <= 1'b0;
                        O_PROG_ZERO_TO_ONE <= 1'b0;
                        state_reg <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    req_reg <= 1'b1;
                    // Plain read needs no command; device powers up in
                    // read mode
                    wr_reg <= (op_reg != OP_READ);
                    cyc_addr_reg <= (op_reg == OP_READ) ? addr_reg :
                        step_addr;
                    cyc_data_reg <= step_data;
                    state_reg <= ST_WAIT;
                end
                ST_WAIT: if (cyc.done) begin
                    if (op_reg == OP_READ) begin
                        O_RSP_DATA <= rd_bits;
                        state_reg <= ST_REPLY;
                    end else if (step_reg != last_step) begin
                        step_reg <= step_reg + 3'h1;
                        state_reg <= ST_ISSUE;
                    end else if (needs_poll) begin
                        // Device runs alone from here on
                        state_reg <= ST_POLL;
                    end else begin
                        state_reg <= ST_REPLY;
                    end
                end
                ST_POLL: begin
                    req_reg <= 1'b1;
                    wr_reg <= 1'b0;
                    cyc_addr_reg <= poll_addr;
                    state_reg <= ST_POLL_WAIT;
                end
                ST_POLL_WAIT: if (cyc.done) begin
                    // CS idles high between polls
                    poll_reg <= poll_reg + 16'h0001;
                    if (poll_ok) begin
                        O_RSP_DATA <= rd_bits;
                        // Only clears bits; flag a 1 asked over a 0
                        if (op_reg == OP_PROGRAM &&
                            (data_reg & ~rd_bits) != '0) begin
                            O_PROG_ZERO_TO_ONE <= 1'b1;
                        end
                        state_reg <= ST_REPLY;
                    end else if (poll_reg == 16'(POLL_MAX - 1)) begin
                        // Give up; reset the die back to read
                        O_RSP_TIMEOUT <= 1'b1;
                        op_reg <= OP_RESET;
                        step_reg <= 3'h0;
                        state_reg <= ST_ISSUE;
                    end else begin
                        // Inverted poll bit means busy
                        state_reg <= ST_POLL;
                    end
                end
                ST_REPLY: begin
                    O_RSP_VALID <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    //==============================================================
    // Pin driver and byte lane steering
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
    wire [DATA_W-1:0] dq_lane = I_DQ[lane_reg*DATA_W +: DATA_W];

    // Sequence of strobes keeps CS low across the WE pulse
    fbc_pin_drv u_drv (
        .i_clk(I_MCLK),
        .i_rst_n(I_ARST_N),
        .cyc(cyc.drv),
        .i_dq(dq_lane),
        .o_cs_n(cs_n),
        .o_oe_n(oe_n),
        .o_we_n(we_n),
        .o_addr(addr),
        .o_dq(dq_out),
        .o_dq_oe(dq_oe)
    );

    // Registered copies so every top output is a flip-flop
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            wire sel = (lane_reg == 2'(g));
            always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
                if (!I_ARST_N) begin
                    O_CS_N[g] <= 1'b1;
                    O_DQ[g*DATA_W +: DATA_W] <= '0;
                    O_DQ_OE[g] <= 1'b0;
                end else begin
                    O_CS_N[g] <= cs_n | ~sel;
                    O_DQ[g*DATA_W +: DATA_W] <= dq_out;
                    O_DQ_OE[g] <= dq_oe & sel;
                end
            end
        end
    endgenerate

    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_OE_N <= 1'b1;
            O_WE_N <= 1'b1;
            O_ADDR <= '0;
        end else begin
            O_OE_N <= oe_n;
            O_WE_N <= we_n;
            O_ADDR <= addr;
        end
    end
endmodule
`default_nettype wire

// >>> tb/fbc_flash_model.sv
// Behavioural flash die: command decoder, byte array and poll status.
// Assumes WE-controlled host writes and one die on each byte lane.
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_model #(
    parameter logic [7:0] AUTO_ID = 8'h5A // Arbitrary value
)(
    input wire logic cs_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [18:0] addr,
    input wire logic [7:0] din,
    input wire logic stuck,
    input wire logic [3:0] busy_len,
    output logic [7:0] dout
);
    logic [7:0] mem [int];
    logic [7:0] last = 8'h00;
    logic [7:0] pv = 8'h00;
    logic [18:0] la = 19'h0_0000;
    logic drv;
    logic seen = 1'b0;
    int st = 0;
    int busy = 0;
    function automatic logic [7:0] rv(input logic [18:0] k);
        if (st == 7) return AUTO_ID;
        return mem.exists(k) ? mem[k] : 8'hFF;
    endfunction
    assign drv = !cs_n && !oe_n && we_n;
    // Released lines show the inverse, never a stale copy
    always @(drv or addr or busy or st) begin
        if (drv) begin
            dout = busy > 0 ? {~pv[7], 7'h00} : rv(addr);
            last = dout;
            seen = 1'b1;
        end else dout = ~last;
    end
    always @(posedge oe_n) begin
        if (seen && busy > 0) busy--;
        seen = 1'b0;
    end
    always @(negedge we_n) if (!cs_n && oe_n) la = addr;
    always @(posedge we_n) if (!cs_n && oe_n) wr(la, din);
    task automatic wr(input logic [18:0] a, input logic [7:0] d);
        logic u1;
        logic u2;
        u1 = a[14:0] == 15'h5555;
        u2 = a[14:0] == 15'h2AAA;
        if (busy > 0) begin
            // Only an exceeded limit lets a reset cut
            if (stuck && d == 8'hF0) busy = 0;
        end else if (d == 8'hF0 && st != 3) st = 0;
        else case (st)
            0, 7: if (u1 && d == 8'hAA) st = 1;
            1: st = (u2 && d == 8'h55) ? 2 : 0;
            2: st = !u1 ? 0 : d == 8'hA0 ? 3 : d == 8'h90 ? 7 :
                d == 8'h80 ? 4 : 0;
            3: begin
                mem[a] = rv(a) & d;
                pv = d;
                busy = stuck ? 1 << 30 : int'(busy_len);
                st = 0;
            end
            4: st = (u1 && d == 8'hAA) ? 5 : 0;
            5: st = (u2 && d == 8'h55) ? 6 : 0;
            6: begin
                pv = 8'h80;
                busy = int'(busy_len);
                st = 0;
                if (u1 && d == 8'h10) mem.delete();
                else if (d == 8'h30) begin
                    foreach (mem[k]) if (k[18:16] == a[18:16]) mem[k] = 8'hFF;
                end else busy = 0;
            end
            default: st = 0;
        endcase
    endtask
endmodule
`default_nettype wire

// >>> tb/fbc_host_assertions.sv
// Checker: pin and handshake relations of the flash host controller.
// Assumes it is bound to fbc_host and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fbc_host_assertions
    import fbc_pkg::*;
#(
    parameter int POLL_MAX = POLL_LIMIT
)(
    // Clock, reset and user port
    input wire logic I_MCLK,
    input wire logic I_ARST_N,
    input wire logic I_CMD_VALID,
    input wire logic [2:0] I_CMD_OP,
    input wire logic [ADDR_W-1:0] I_CMD_ADDR,
    input wire logic [DATA_W-1:0] I_CMD_DATA,
    input wire logic [1:0] I_CMD_LANE,
    input wire logic O_CMD_READY,
    input wire logic O_RSP_VALID,
    input wire logic [DATA_W-1:0] O_RSP_DATA,
    input wire logic O_RSP_TIMEOUT,
    input wire logic O_PROG_ZERO_TO_ONE,
    // Flash pins
    input wire logic [LANES-1:0] O_CS_N,
    input wire logic O_OE_N,
    input wire logic O_WE_N,
    input wire logic [ADDR_W-1:0] O_ADDR,
    input wire logic [LANES*DATA_W-1:0] I_DQ,
    input wire logic [LANES*DATA_W-1:0] O_DQ,
    input wire logic [LANES-1:0] O_DQ_OE
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_ARST_N);
    property p_read_combo;
        !O_OE_N |-> O_WE_N && O_DQ_OE == '0;
    endproperty
    a_read_combo: assert property (p_read_combo) else $error("bus fight");
    property p_float;
        $rose(O_OE_N) |-> (O_DQ_OE == '0) [*2];
    endproperty
    a_float: assert property (p_float) else $error("float too short");
    property p_write_combo;
        !O_WE_N |-> O_OE_N && O_CS_N != 4'hF && (O_DQ_OE & ~O_CS_N) != '0;
    endproperty
    a_write_combo: assert property (p_write_combo) else $error("bad write");
    property p_wpulse;
        $fell(O_WE_N) |-> !O_WE_N [*3] ##1 O_WE_N;
    endproperty
    a_wpulse: assert property (p_wpulse) else $error("strobe width");
    property p_hold;
        !O_WE_N && $past(!O_WE_N) |-> $stable(O_ADDR) && $stable(O_DQ);
    endproperty
    a_hold: assert property (p_hold) else $error("moved in strobe");
    property p_one_lane;
        $onehot0(~O_CS_N);
    endproperty
    a_one_lane: assert property (p_one_lane) else $error("two lanes");
    property p_rsp;
        O_RSP_VALID |=> O_CMD_READY && !O_RSP_VALID;
    endproperty
    a_rsp: assert property (p_rsp) else $error("response shape");
    property p_take;
        I_CMD_VALID && O_CMD_READY |=> !O_CMD_READY;
    endproperty
    a_take: assert property (p_take) else $error("not taken");
endmodule
bind fbc_host fbc_host_assertions #(.POLL_MAX(POLL_MAX)) fbc_host_assertions_i (
    .I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_CMD_VALID(I_CMD_VALID),
    .I_CMD_OP(I_CMD_OP), .I_CMD_ADDR(I_CMD_ADDR), .I_CMD_DATA(I_CMD_DATA),
    .I_CMD_LANE(I_CMD_LANE), .O_CMD_READY(O_CMD_READY),
    .O_RSP_VALID(O_RSP_VALID), .O_RSP_DATA(O_RSP_DATA),
    .O_RSP_TIMEOUT(O_RSP_TIMEOUT), .O_PROG_ZERO_TO_ONE(O_PROG_ZERO_TO_ONE),
    .O_CS_N(O_CS_N), .O_OE_N(O_OE_N), .O_WE_N(O_WE_N), .O_ADDR(O_ADDR),
    .I_DQ(I_DQ), .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE));
`default_nettype wire

// >>> tb/tb.sv
// Testbench: flash host controller against four behavioural dies.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fbc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic v = 1'b0;
    logic [2:0] op = 3'h0;
    logic [18:0] a = 19'h0_0000;
    logic [7:0] d = 8'h00;
    logic [1:0] ln = 2'h0;
    logic stuck = 1'b0;
    logic [3:0] blen = 4'h0;
    logic ready, rv, tmo, z2o, oe_n, we_n;
    logic [7:0] rdat;
    logic [3:0] cs_n, dq_oe;
    logic [18:0] pa;
    logic [31:0] dq_in, dq_o, mdq;
    logic [15:0] seed = 16'h0031;
    logic [15:0] t;
    logic [7:0] rm [int];
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int k0;
    initial forever #10 clk = ~clk;
    fbc_host #(.POLL_MAX(8)) fbc_host_i (.I_MCLK(clk), .I_ARST_N(rst_n),
        .I_CMD_VALID(v), .I_CMD_OP(op), .I_CMD_ADDR(a), .I_CMD_DATA(d),
        .I_CMD_LANE(ln), .O_CMD_READY(ready), .O_RSP_VALID(rv),
        .O_RSP_DATA(rdat), .O_RSP_TIMEOUT(tmo), .O_PROG_ZERO_TO_ONE(z2o),
        .O_CS_N(cs_n), .O_OE_N(oe_n), .O_WE_N(we_n), .O_ADDR(pa),
        .I_DQ(dq_in), .O_DQ(dq_o), .O_DQ_OE(dq_oe));
    for (genvar g = 0; g < LANES; g++) begin : g_die
        fbc_flash_model fbc_flash_model_i (.cs_n(cs_n[g]), .oe_n(oe_n),
            .we_n(we_n), .addr(pa), .din(dq_o[8*g+:8]), .stuck(stuck),
            .busy_len(blen), .dout(mdq[8*g+:8]));
        assign dq_in[8*g+:8] = dq_oe[g] ? dq_o[8*g+:8] : mdq[8*g+:8];
    end
    function automatic logic [15:0] lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] ex(input int k);
        return rm.exists(k) ? rm[k] : 8'hFF;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [2:0] o, input int k, input logic [7:0] dd);
        @(negedge clk);
        {op, a, d, ln, v} = {o, k[18:0], dd, k[20:19], 1'b1};
        while (ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        v = 1'b0;
        while (rv !== 1'b1) @(negedge clk);
    endtask
    task automatic rdc(input int k);
        run(OP_READ, k, 8'h00);
        chk(rdat, ex(k));
    endtask
    task automatic prg(input int k, input logic [7:0] dd);
        logic z;
        z = |(dd & ~ex(k));
        rm[k] = ex(k) & dd;
        seed = lf(seed);
        // Busy span must end inside the eight polls
        blen = {1'b0, seed[2:0]};
        run(OP_PROGRAM, k, dd);
        chk(rdat, rm[k]);
        chk({7'h00, z2o}, {7'h00, z});
    endtask
    task automatic conclude;
        if (err_total == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            seed = lf(seed);
            rdc({i[1:0], seed[2:0], seed});
        end
        prg(21'h1F_FFFF, 8'h3C);
        for (int i = 0; i < 10; i++) begin
            t = seed;
            seed = lf(seed);
            k0 = {t[1:0], t[4:2], seed};
            prg(k0, t[15:8]);
        end
        prg(k0, 8'h0F);
        prg(k0, 8'h7F);
        foreach (rm[k]) rdc(k);
        run(OP_SECTOR_ERASE, k0, 8'h00);
        chk(rdat[7], 1'b1);
        foreach (rm[k]) if (k[20:16] == k0[20:16]) rm[k] = 8'hFF;
        foreach (rm[k]) rdc(k);
        run(OP_AUTOSEL, 21'h08_0000, 8'h00);
        run(OP_READ, 21'h08_0000, 8'h00);
        chk(rdat, 8'h5A);
        run(OP_RESET, 21'h08_0000, 8'h00);
        foreach (rm[k]) rdc(k);
        stuck = 1'b1;
        run(OP_PROGRAM, 21'h11_2345, 8'h00);
        chk({7'h00, tmo}, 8'h01);
        stuck = 1'b0;
        rm[21'h11_2345] = 8'h00;
        rdc(21'h11_2345);
        run(OP_CHIP_ERASE, 21'h18_0000, 8'h00);
        foreach (rm[k]) if (k[20:19] == 2'h3) rm[k] = 8'hFF;
        foreach (rm[k]) rdc(k);
        conclude();
    end
endmodule
`default_nettype wire
